// *** include/pwr_seq_map.svh ***
// Constants of the supply-rail sequencer: clock rate, rail bit positions,
// step times and their conversion to clock cycles.
// Assumes that every user includes it by its bare name.
`ifndef PWR_SEQ_MAP_SVH
`define PWR_SEQ_MAP_SVH

// ---------------------------------------------------------------------------
// Clock and timer
// ---------------------------------------------------------------------------
`define CLK_MHZ 25
`define US_TO_CYC(t) ((t) * `CLK_MHZ)
`define TMR_W 16
`define RAIL_COUNT 9

// ---------------------------------------------------------------------------
// Rail bit positions in the rail vector
// ---------------------------------------------------------------------------
`define BIT_BBR 0
`define BIT_SOC 1
`define BIT_SD 8
`define KEEP_MASK 9'h003
`define OTHERS_MASK 9'h1fc

// ---------------------------------------------------------------------------
// Ramp steps: index of the 3.3 V step and of the last step
// ---------------------------------------------------------------------------
`define STEP_V33 3'h6
`define STEP_LAST 3'h7

// ---------------------------------------------------------------------------
// Step times in microseconds, typical spacing used and least allowed
// ---------------------------------------------------------------------------
`define T_REQ_CORE_US 1000
`define T_CORE_CPU_US 500
`define T_CPU_LV_US 500
`define T_LV_V18_US 250
`define T_LV_V18_MIN_US 200
`define T_V18_DH_US 500
`define T_V18_DH_MIN_US 400
`define T_DH_DQ_US 300
`define T_DQ_V33_US 100
`define T_V33_SD_US 1000
`define T_POR_US 500
`define T_POR_MIN_US 400

`endif

// *** include/pwr_seq_pkg.sv ***
// Types shared by the supply-rail sequencer and its step timer.
// Assumes nothing beyond a SystemVerilog compiler.
package pwr_seq_pkg;

  // -------------------------------------------------------------------------
  // Rail vector, one bit per rail group, battery-backed rail in bit 0
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic sd_card_io_rail;
    logic io_3v3_rails;
    logic dram_io_rail;
    logic dram_high_rail;
    logic io_1v8_rails;
    logic low_voltage_analog_rails;
    logic cpu_rail;
    logic soc_core_rail;
    logic battery_backed_rail;
  } rails_s;

  typedef logic [15:0] count_t;

  // -------------------------------------------------------------------------
  // Sequencer states
  // -------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF,
    ST_BBR_UP,
    ST_WAIT_REQ,
    ST_RAMP,
    ST_WAIT_GOOD,
    ST_POR_WAIT,
    ST_RUN,
    ST_PD_OTHERS,
    ST_PD_CORE,
    ST_PD_BBR
  } seq_state_e;

endpackage

// *** verilog/step_timer.sv ***
// One-shot down counter that times the spacing between sequencer steps.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`include "pwr_seq_map.svh"

module step_timer (
  input wire logic clock,
  input wire logic rstn,
  input wire logic start,
  input wire pwr_seq_pkg::count_t count,
  output logic done
);

  pwr_seq_pkg::count_t cnt_q;
  logic busy_q;

  // Done is a one-cycle pulse; a start in the same cycle rearms at once.
  assign done = busy_q && (cnt_q == '0);

  // Load on start, count down while armed, disarm after the pulse.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q <= count;
      busy_q <= 1'b1;
    end else if (done) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

endmodule

// *** verilog/pwr_seq.sv ***
// Power-management sequencer that enables the supply rails of an
// applications processor in order and drives its power-on reset.
// Assumes synchronous power-good inputs and a power-on request from the
// processor, both sampled on clock.
//
// Operation
// - The CPU rail starts after the core rail, 0.5 ms later here.
// - The low-voltage analog rails start after the later of core and CPU, 0.5 ms later.
// - The 1.8 V rails start at least 0.2 ms after the analog rails, 0.25 ms here.
// - The DRAM high rail starts at least 0.4 ms after the 1.8 V rails, 0.5 ms here.
// - The DRAM I/O rail starts after the DRAM high rail, 0.3 ms later.
// - The 3.3 V rails start after the DRAM I/O rail, 0.1 ms later.
// - A switchable SD rail starts last, 1 ms after 3.3 V; a fixed one starts with 3.3 V.
// - Reset stays low during power-up and is released at least 0.4 ms after all rails are good.
// - Reset stays low whenever the core rail is off and the battery-backed rail is on.
// - At power-down the core rail goes after the others and the battery-backed rail last.
`timescale 1ns/10ps
`include "pwr_seq_map.svh"

module pwr_seq #(
  parameter int REQ_CORE_CYC = `US_TO_CYC(`T_REQ_CORE_US),
  parameter int CORE_CPU_CYC = `US_TO_CYC(`T_CORE_CPU_US),
  parameter int CPU_LV_CYC = `US_TO_CYC(`T_CPU_LV_US),
  parameter int LV_V18_CYC = `US_TO_CYC(`T_LV_V18_US),
  parameter int V18_DH_CYC = `US_TO_CYC(`T_V18_DH_US),
  parameter int DH_DQ_CYC = `US_TO_CYC(`T_DH_DQ_US),
  parameter int DQ_V33_CYC = `US_TO_CYC(`T_DQ_V33_US),
  parameter int V33_SD_CYC = `US_TO_CYC(`T_V33_SD_US),
  parameter int POR_CYC = `US_TO_CYC(`T_POR_US),
  parameter int LV_V18_MIN_CYC = `US_TO_CYC(`T_LV_V18_MIN_US),
  parameter int V18_DH_MIN_CYC = `US_TO_CYC(`T_V18_DH_MIN_US),
  parameter int POR_MIN_CYC = `US_TO_CYC(`T_POR_MIN_US)
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic system_enable,
  input wire logic sd_dynamic,
  input wire logic power_on_request,
  input wire pwr_seq_pkg::rails_s power_good,
  output pwr_seq_pkg::rails_s rail_enable,
  output logic por_n,
  output logic sequence_done,
  output logic battery_backed_mode
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  pwr_seq_pkg::seq_state_e state_q, state_d;
  logic [2:0] step_q, step_d;
  logic [8:0] en_q, en_d;
  logic por_n_q, por_n_d;
  logic done_q, done_d;
  logic bbm_q, bbm_d;
  logic tmr_start;
  pwr_seq_pkg::count_t tmr_load;
  logic tmr_done;

  // -------------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------------
  wire [8:0] pg_w = power_good;
  wire pwr_seq_pkg::count_t delay_w [8];
  wire [2:0] step_next_w = step_q + 3'h1;
  wire fixed_sd_w = !sd_dynamic && (step_q == `STEP_V33);
  wire last_step_w = (step_q == `STEP_LAST) || fixed_sd_w;
  wire [8:0] sd_mask_w = fixed_sd_w ? 9'h100 : 9'h000;
  wire [8:0] step_mask_w = (9'h002 << step_q) | sd_mask_w;
  wire all_good_w = ((pg_w & en_q) == en_q);
  wire others_low_w = ((pg_w & `OTHERS_MASK) == 9'h000);
  wire stop_w = !system_enable || !power_on_request;

  // Spacing before each ramp step, from request to core up to 3.3 V to SD.
  assign delay_w[0] = pwr_seq_pkg::count_t'(REQ_CORE_CYC);
  assign delay_w[1] = pwr_seq_pkg::count_t'(CORE_CPU_CYC);
  assign delay_w[2] = pwr_seq_pkg::count_t'(CPU_LV_CYC);
  assign delay_w[3] = pwr_seq_pkg::count_t'(LV_V18_CYC);
  assign delay_w[4] = pwr_seq_pkg::count_t'(V18_DH_CYC);
  assign delay_w[5] = pwr_seq_pkg::count_t'(DH_DQ_CYC);
  assign delay_w[6] = pwr_seq_pkg::count_t'(DQ_V33_CYC);
  assign delay_w[7] = pwr_seq_pkg::count_t'(V33_SD_CYC);

  // All spacing is counted on the system clock by one shared timer.
  step_timer u_timer (
    .clock(clock),
    .rstn(rstn),
    .start(tmr_start),
    .count(tmr_load),
    .done(tmr_done)
  );

  // -------------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------------
  // Reset is only ever released on leaving the POR wait, so it is high only in
  // the run state, and never in battery-backed mode with the core rail off.
  always_comb begin
    state_d = state_q;
    step_d = step_q;
    en_d = en_q;
    por_n_d = por_n_q;
    done_d = done_q;
    bbm_d = bbm_q;
    tmr_start = 1'b0;
    tmr_load = delay_w[step_next_w];
    unique case (state_q)
      pwr_seq_pkg::ST_OFF: begin
        if (system_enable) begin
          en_d[`BIT_BBR] = 1'b1;
          state_d = pwr_seq_pkg::ST_BBR_UP;
        end
      end
      pwr_seq_pkg::ST_BBR_UP: begin
        if (!system_enable) begin
          state_d = pwr_seq_pkg::ST_PD_BBR;
        end else if (power_good.battery_backed_rail) begin
          state_d = pwr_seq_pkg::ST_WAIT_REQ;
        end
      end
      pwr_seq_pkg::ST_WAIT_REQ: begin
        if (!system_enable) begin
          state_d = pwr_seq_pkg::ST_PD_BBR;
        end else if (power_on_request) begin
          tmr_start = 1'b1;
          tmr_load = delay_w[0];
          step_d = 3'h0;
          bbm_d = 1'b0;
          state_d = pwr_seq_pkg::ST_RAMP;
        end
      end
      pwr_seq_pkg::ST_RAMP: begin
        if (stop_w) begin
          state_d = pwr_seq_pkg::ST_PD_OTHERS;
        end else if (tmr_done) begin
          en_d = en_q | step_mask_w;
          if (last_step_w) begin
            state_d = pwr_seq_pkg::ST_WAIT_GOOD;
          end else begin
            step_d = step_next_w;
            tmr_start = 1'b1;
          end
        end
      end
      pwr_seq_pkg::ST_WAIT_GOOD: begin
        if (stop_w) begin
          state_d = pwr_seq_pkg::ST_PD_OTHERS;
        end else if (all_good_w) begin
          tmr_start = 1'b1;
          tmr_load = pwr_seq_pkg::count_t'(POR_CYC);
          state_d = pwr_seq_pkg::ST_POR_WAIT;
        end
      end
      pwr_seq_pkg::ST_POR_WAIT: begin
        if (stop_w) begin
          state_d = pwr_seq_pkg::ST_PD_OTHERS;
        end else if (!all_good_w) begin
          state_d = pwr_seq_pkg::ST_WAIT_GOOD;
        end else if (tmr_done) begin
          por_n_d = 1'b1;
          done_d = 1'b1;
          state_d = pwr_seq_pkg::ST_RUN;
        end
      end
      pwr_seq_pkg::ST_RUN: begin
        if (stop_w || !all_good_w) begin
          por_n_d = 1'b0;
          done_d = 1'b0;
          state_d = pwr_seq_pkg::ST_PD_OTHERS;
        end
      end
      pwr_seq_pkg::ST_PD_OTHERS: begin
        en_d = en_q & `KEEP_MASK;
        if (others_low_w) begin
          state_d = pwr_seq_pkg::ST_PD_CORE;
        end
      end
      pwr_seq_pkg::ST_PD_CORE: begin
        en_d[`BIT_SOC] = 1'b0;
        if (!power_good.soc_core_rail) begin
          if (!system_enable) begin
            state_d = pwr_seq_pkg::ST_PD_BBR;
          end else if (!power_on_request) begin
            bbm_d = 1'b1;
            state_d = pwr_seq_pkg::ST_WAIT_REQ;
          end
        end
      end
      pwr_seq_pkg::ST_PD_BBR: begin
        en_d = 9'h000;
        bbm_d = 1'b0;
        state_d = pwr_seq_pkg::ST_OFF;
      end
      default: begin
        state_d = pwr_seq_pkg::ST_PD_OTHERS;
      end
    endcase
  end

  // Register update.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_q <= pwr_seq_pkg::ST_OFF;
      step_q <= 3'h0;
      en_q <= 9'h000;
      por_n_q <= 1'b0;
      done_q <= 1'b0;
      bbm_q <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      en_q <= en_d;
      por_n_q <= por_n_d;
      done_q <= done_d;
      bbm_q <= bbm_d;
    end
  end

  // Outputs straight from flip-flops.
  assign rail_enable = pwr_seq_pkg::rails_s'(en_q);
  assign por_n = por_n_q;
  assign sequence_done = done_q;
  assign battery_backed_mode = bbm_q;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  // Helper: cycles since the last rail rise and since all rails were good.
  logic [8:0] en_prev_q;
  logic [15:0] gap_q, good_cnt_q;
  wire rise_w = |(en_q & ~en_prev_q);
  always_ff @(posedge clock) begin
    if (!rstn) begin
      en_prev_q <= 9'h000;
      gap_q <= 16'h0000;
      good_cnt_q <= 16'h0000;
    end else begin
      en_prev_q <= en_q;
      gap_q <= rise_w ? 16'h0001 : gap_q + {15'h0000, gap_q != 16'hffff};
      good_cnt_q <= !all_good_w ? 16'h0000 : good_cnt_q + {15'h0000, good_cnt_q != 16'hffff};
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence others_off_s;
    (en_q & `OTHERS_MASK) == 9'h000;
  endsequence

  core_after_req_a: assert property ($rose(en_q[1]) |-> $past(power_on_request) && gap_q > 16'h0000) else $error("core rail started without request");
  cpu_after_core_a: assert property (en_q[2] |-> en_q[1]) else $error("cpu rail on without core rail");
  analog_after_cpu_a: assert property ($rose(en_q[3]) |-> $past(en_q[2], 2)) else $error("analog rails started early");
  io18_spacing_a: assert property ($rose(en_q[4]) |-> en_q[3] && gap_q >= 16'(LV_V18_MIN_CYC)) else $error("1.8 V rails spaced too closely");
  dram_high_gap_a: assert property ($rose(en_q[5]) |-> en_q[4] && gap_q >= 16'(V18_DH_MIN_CYC)) else $error("DRAM high rail spaced too closely");
  dram_io_order_a: assert property (en_q[6] |-> en_q[5]) else $error("DRAM io rail before DRAM high rail");
  io33_order_a: assert property ($rose(en_q[7]) |-> $past(en_q[6])) else $error("3.3 V rails before DRAM io rail");
  sd_last_a: assert property ($rose(en_q[8]) && sd_dynamic |-> $past(en_q[7])) else $error("switchable SD rail not last");
  por_release_a: assert property ($rose(por_n_q) |-> $past(good_cnt_q) >= 16'(POR_MIN_CYC) && en_q[8:7] != 2'h0) else $error("reset released too early");
  por_bbm_a: assert property (en_q[0] && !en_q[1] |-> !por_n_q) else $error("reset high with core rail off");
  core_off_last_a: assert property ($fell(en_q[1]) |-> others_off_s ##1 !en_q[1]) else $error("core rail dropped before others");
  bbr_off_last_a: assert property ($fell(en_q[0]) |-> en_q == 9'h000 && $past(en_q[1]) == 1'b0) else $error("battery rail dropped early");
  por_needs_good_a: assert property (por_n_q |-> all_good_w or ##[0:1] !por_n_q) else $error("reset high with a rail not good");

endmodule

// *** dv/soc_device_model.sv ***
// Behavioural model of the processor that the sequencer powers.
// Assumes the bench's clock and reset; it changes its outputs on the falling edge.
`timescale 1ns/10ps

module soc_device_model #(
  parameter int REQ_DLY = 5
) (
  input wire logic clock,
  input wire logic rstn,
  input wire pwr_seq_pkg::rails_s rail_enable,
  input wire logic req_off,
  input wire pwr_seq_pkg::rails_s sag,
  output pwr_seq_pkg::rails_s power_good,
  output logic power_on_request
);
  // -------------------------------------------------------------------------
  // Supply settling and power-on request
  // -------------------------------------------------------------------------
  logic [8:0] p1_q, p2_q, p3_q;
  int cnt_q;

  // Each rail settles three cycles after its enable, and takes as long to
  // decay, so the sequencer never sees a rail die the moment it lets go.
  always @(negedge clock) begin
    if (!rstn) begin
      p1_q <= '0;
      p2_q <= '0;
      p3_q <= '0;
    end else begin
      p1_q <= rail_enable;
      p2_q <= p1_q;
      p3_q <= p2_q;
    end
  end

  // A commanded sag pulls a good rail low, as a real supply fault would.
  assign power_good = pwr_seq_pkg::rails_s'(p3_q & ~sag);

  // The request follows a good battery rail after REQ_DLY cycles; with REQ_DLY at zero it is high regardless of that rail.
  always @(negedge clock) begin
    if (!power_good.battery_backed_rail) begin
      cnt_q <= 0;
    end else if (cnt_q < REQ_DLY) begin
      cnt_q <= cnt_q + 1;
    end
  end
  assign power_on_request = (cnt_q >= REQ_DLY) && !req_off;
endmodule

// *** dv/soc_power_rail_sequencer_bench.sv ***
// Self-checking bench for the supply-rail sequencer and its processor model.
// Assumes the design's package and short step parameters set below.
`timescale 1ns/10ps

module soc_power_rail_sequencer_bench;
  localparam int REQ_CORE = 30, CORE_CPU = 20, CPU_LV = 20, LV_V18 = 30, V18_DH = 40;
  localparam int DH_DQ = 20, DQ_V33 = 20, V33_SD = 30, POR = 40, PG_DLY = 3;
  typedef struct {logic [9:0] what; int lo; int hi;} note_s;
  logic clock = 0, rstn = 0, system_enable = 0, sd_dynamic = 0, req_off = 0;
  logic power_on_request, por_n, sequence_done, battery_backed_mode, req_prev = 0;
  pwr_seq_pkg::rails_s power_good, rail_enable, sag = '0;
  logic [9:0] prev_v = '0, rose;
  note_s notes[$], n;
  int bad_count = 0, checks_done = 0, cyc = 0, ref_cyc = 0, seed = 32'h1a44, rnd;

  always #20 clock = ~clock;

  pwr_seq #(.REQ_CORE_CYC(REQ_CORE), .CORE_CPU_CYC(CORE_CPU), .CPU_LV_CYC(CPU_LV),
    .LV_V18_CYC(LV_V18), .V18_DH_CYC(V18_DH), .DH_DQ_CYC(DH_DQ), .DQ_V33_CYC(DQ_V33),
    .V33_SD_CYC(V33_SD), .POR_CYC(POR), .LV_V18_MIN_CYC(20), .V18_DH_MIN_CYC(30),
    .POR_MIN_CYC(30)) DUT (.clock(clock), .rstn(rstn), .system_enable(system_enable),
    .sd_dynamic(sd_dynamic), .power_on_request(power_on_request), .power_good(power_good),
    .rail_enable(rail_enable), .por_n(por_n), .sequence_done(sequence_done),
    .battery_backed_mode(battery_backed_mode));

  soc_device_model #(.REQ_DLY(5)) partner (.clock(clock), .rstn(rstn),
    .rail_enable(rail_enable), .req_off(req_off), .sag(sag), .power_good(power_good),
    .power_on_request(power_on_request));

  // -------------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------------
  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic note(input logic [9:0] w, input int lo, input int hi);
    notes.push_back('{w, lo, hi});
  endtask

  // Notes every rise of a ramp in order, then waits for reset release.
  task automatic power_up(input bit first);
    if (first) note(10'h001, 1, 100);
    note(10'h002, REQ_CORE + 1, REQ_CORE + 2);
    note(10'h004, CORE_CPU + 1, CORE_CPU + 1);
    note(10'h008, CPU_LV + 1, CPU_LV + 1);
    note(10'h010, LV_V18 + 1, LV_V18 + 1);
    note(10'h020, V18_DH + 1, V18_DH + 1);
    note(10'h040, DH_DQ + 1, DH_DQ + 1);
    note(sd_dynamic ? 10'h080 : 10'h180, DQ_V33 + 1, DQ_V33 + 1);
    if (sd_dynamic) note(10'h100, V33_SD + 1, V33_SD + 1);
    note(10'h200, POR + 1, POR + PG_DLY + 3);
    wait (por_n === 1'b1);
    // The watcher takes the release note one edge later, so let that edge pass first.
    repeat (2) @(negedge clock);
    check("notes left", 10'(notes.size()), 10'h000);
    check("sequence_done", {9'h0, sequence_done}, 10'h001);
    check("battery_backed_mode", {9'h0, battery_backed_mode}, 10'h000);
  endtask

  // -------------------------------------------------------------------------
  // Watcher: every cycle with a rise of enables or of por_n takes the oldest note.
  // -------------------------------------------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (cyc >= 5000) begin
      bad_count++;
      results();
    end else begin
      rose = {por_n, rail_enable} & ~prev_v;
      prev_v = {por_n, rail_enable};
      if (power_on_request && !req_prev) ref_cyc = cyc;
      req_prev = power_on_request;
      if (rstn && rose != 10'h000) begin
        // An unexpected rise meets an empty note and is counted as a mismatch.
        if (notes.size() > 0) begin
          n = notes.pop_front();
        end else begin
          n = '{10'h000, 0, 0};
        end
        check("rising outputs", rose, n.what);
        check("step spacing", {9'h0, cyc - ref_cyc inside {[n.lo:n.hi]}}, 10'h001);
        ref_cyc = cyc;
      end
      if (rstn && !power_good.soc_core_rail) check("por_n core off", {9'h0, por_n}, 10'h000);
    end
  end

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clock);
    check("reset outputs", {rail_enable, por_n}, 10'h000);
    rstn = 1;
    system_enable = 1;
    rnd = $random(seed);
    sd_dynamic = rnd[0];
    power_up(1'b1);
    // The processor withdraws its request: down to battery-backed mode.
    req_off = 1;
    wait (rail_enable[8:2] == 7'h00);
    check("core after others", {9'h0, rail_enable.soc_core_rail}, 10'h001);
    wait (battery_backed_mode === 1'b1);
    check("battery mode rails", {1'b0, rail_enable}, 10'h001);
    @(negedge clock);
    req_off = 0;
    sd_dynamic = ~sd_dynamic;
    power_up(1'b0);
    // A sag on one running rail must drop reset and power down.
    rnd = $random(seed);
    sag = pwr_seq_pkg::rails_s'(9'h004 << (rnd[7:0] % 7));
    repeat (3) @(negedge clock);
    check("por_n on sag", {9'h0, por_n}, 10'h000);
    req_off = 1;
    wait (battery_backed_mode === 1'b1);
    check("sag down rails", {1'b0, rail_enable}, 10'h001);
    @(negedge clock);
    sag = '0;
    req_off = 0;
    power_up(1'b0);
    // Full power-down keeps the battery rail to the last.
    system_enable = 0;
    wait (rail_enable.soc_core_rail === 1'b0);
    check("battery last", {1'b0, rail_enable}, 10'h001);
    wait (rail_enable.battery_backed_rail === 1'b0);
    check("por_n off", {9'h0, por_n}, 10'h000);
    results();
  end
endmodule
